// ### csf_map.svh
`ifndef CSF_MAP_SVH
`define CSF_MAP_SVH

`define CSF_ADDR_CTRL 8'h00
`define CSF_ADDR_TADDR 8'h04
`define CSF_ADDR_TDATA 8'h08
`define CSF_ADDR_TLEN 8'h0c
`define CSF_ADDR_STATUS 8'h10
`define CSF_ADDR_CMDS 8'h14
`define CSF_ADDR_FCNT 8'h18

`define CSF_CTRL_EN 0
`define CSF_CTRL_CHK 1
`define CSF_CTRL_TMPL 2
`define CSF_CTRL_SEL_LO 3
`define CSF_CTRL_CMD 6
`define CSF_CTRL_FLOW 7
`define CSF_CTRL_RST 8'h00

`define CSF_TADDR_SEL_LO 16

`define CSF_STX 8'h02
`define CSF_CR 8'h0d
`define CSF_XON 8'h11
`define CSF_XOFF 8'h13
`define CSF_ASCII_ZERO 8'h30
`define CSF_ASCII_SPACE 8'h20
`define CSF_CASE_MASK 8'hdf
`define CSF_CMD_CLEAR 8'h43
`define CSF_CMD_TARE 8'h54
`define CSF_CMD_PRINT 8'h50
`define CSF_CMD_ZERO 8'h5a

`define CSF_FRAME_LEN 10'd17
`define CSF_FRAME_LEN_CHK 10'd18
`define CSF_TMPL_COUNT 5
`define CSF_TMPL_BYTES 1000
`define CSF_TMPL_MEM (`CSF_TMPL_COUNT * `CSF_TMPL_BYTES)

`define CSF_CLK_MHZ 100
`define CSF_TICK_US 1000
`define CSF_TICK_CYC (`CSF_TICK_US * `CSF_CLK_MHZ)
`define CSF_FRAME_GAP_MS 6'd50
`endif

// ### csf_pkg.sv
package csf_pkg;
    typedef struct packed {
        logic [5:0][3:0] wt_bcd;
        logic [5:0][3:0] tare_bcd;
        logic [2:0] dp_code;
        logic [1:0] incr_code;
        logic net;
        logic negative;
        logic out_of_range;
        logic motion;
        logic kg;
        logic zero_not_captured;
        logic [2:0] unit_code;
        logic print_req;
        logic expand;
    } csf_scale_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_LOAD = 2'b01,
        TX_SEND = 2'b10
    } csf_tx_state_t;
endpackage : csf_pkg

// ### csf_framer.sv
`include "csf_map.svh"

module csf_framer #(
    parameter int TICK_CYC = `CSF_TICK_CYC
) (
    input wire logic MCLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire csf_pkg::csf_scale_t SCALE_IN,
    output logic [7:0] TX_DATA_OUT,
    output logic TX_VALID_OUT,
    input wire logic TX_READY_IN,
    input wire logic [7:0] RX_DATA_IN,
    input wire logic RX_VALID_IN,
    output logic CLEAR_OUT,
    output logic TARE_OUT,
    output logic PRINT_OUT,
    output logic ZERO_OUT
);
    logic [7:0] ctrl_q;
    logic [2:0] taddr_sel_q;
    logic [9:0] taddr_idx_q;
    logic [9:0] tlen_q [`CSF_TMPL_COUNT];
    logic [7:0] tmpl_mem [`CSF_TMPL_MEM];
    logic [3:0] cmd_flags_q;
    logic [15:0] frame_cnt_q;
    logic paused_q;

    csf_pkg::csf_tx_state_t state_q;
    csf_pkg::csf_scale_t snap_q;
    logic cap_tmpl_q;
    logic [2:0] cap_sel_q;
    logic [9:0] cap_len_q;
    logic [9:0] idx_q;
    logic [6:0] sum_q;
    logic [16:0] tick_q;
    logic [5:0] ms_q;

    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [7:0] tx_data_q;
    logic tx_valid_q;
    logic [3:0] cmd_pulse_q;

    logic setup_ph;
    logic wr_acc;
    logic mapped;
    logic tmpl_wr_ok;
    logic [12:0] tmpl_wr_addr;
    logic [12:0] tmpl_rd_addr;
    logic [7:0] status_a;
    logic [7:0] status_b;
    logic [7:0] status_c;
    logic [7:0] wt_chr [6];
    logic [7:0] ta_chr [6];
    logic [7:0] frame_byte;
    logic [7:0] next_byte;
    logic gap_done;
    logic start_ok;
    logic [9:0] start_len;
    logic [7:0] rx_upper;
    logic [3:0] cmd_hit;
    logic rx_cmd_ok;
    logic cmd_wr;

    assign setup_ph = PSEL_IN && !PENABLE_IN;
    assign wr_acc = PSEL_IN && PENABLE_IN && pready_q && PWRITE_IN && !pslverr_q;
    assign mapped = (PADDR_IN == `CSF_ADDR_CTRL) || (PADDR_IN == `CSF_ADDR_TADDR) ||
        (PADDR_IN == `CSF_ADDR_TDATA) || (PADDR_IN == `CSF_ADDR_TLEN) ||
        (PADDR_IN == `CSF_ADDR_STATUS) || (PADDR_IN == `CSF_ADDR_CMDS) ||
        (PADDR_IN == `CSF_ADDR_FCNT);
    assign tmpl_wr_addr = 13'(taddr_sel_q) * 13'(`CSF_TMPL_BYTES) + 13'(taddr_idx_q);
    // writes past the end of a template are dropped rather than wrapped
    assign tmpl_wr_ok = (taddr_sel_q < 3'(`CSF_TMPL_COUNT)) &&
        (taddr_idx_q < 10'(`CSF_TMPL_BYTES));
    assign tmpl_rd_addr = 13'(cap_sel_q) * 13'(`CSF_TMPL_BYTES) + 13'(idx_q);
    assign cmd_wr = wr_acc && (PADDR_IN == `CSF_ADDR_CMDS);

    // apb: zero wait states, data prepared in the setup cycle
    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= setup_ph;
            pslverr_q <= setup_ph && !mapped;
            if (setup_ph)
            begin
                case (PADDR_IN)
                    `CSF_ADDR_CTRL: prdata_q <= {24'h00_0000, ctrl_q};
                    `CSF_ADDR_TADDR: prdata_q <= {13'h0000, taddr_sel_q, 6'h00, taddr_idx_q};
                    `CSF_ADDR_TLEN: prdata_q <= (taddr_sel_q < 3'(`CSF_TMPL_COUNT)) ?
                        {22'h00_0000, tlen_q[taddr_sel_q]} : 32'h0000_0000;
                    `CSF_ADDR_STATUS: prdata_q <= {12'h000, idx_q, 6'h00,
                        cap_tmpl_q, paused_q, 1'b0, (state_q != csf_pkg::TX_IDLE)};
                    `CSF_ADDR_CMDS: prdata_q <= {28'h000_0000, cmd_flags_q};
                    `CSF_ADDR_FCNT: prdata_q <= {16'h0000, frame_cnt_q};
                    default: prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // frame format stays fixed; software picks enable, mode, checksum, template, command decode and xon/xoff flow control
    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            ctrl_q <= `CSF_CTRL_RST;
        end
        else if (wr_acc && (PADDR_IN == `CSF_ADDR_CTRL))
        begin
            ctrl_q <= PWDATA_IN[7:0];
        end
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            taddr_sel_q <= 3'h0;
            taddr_idx_q <= 10'h000;
        end
        else if (wr_acc && (PADDR_IN == `CSF_ADDR_TADDR))
        begin
            taddr_sel_q <= PWDATA_IN[`CSF_TADDR_SEL_LO +: 3];
            taddr_idx_q <= PWDATA_IN[9:0];
        end
        else if (wr_acc && (PADDR_IN == `CSF_ADDR_TDATA) && tmpl_wr_ok)
        begin
            taddr_idx_q <= taddr_idx_q + 10'h001;
        end
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (wr_acc && (PADDR_IN == `CSF_ADDR_TDATA) && tmpl_wr_ok)
        begin
            tmpl_mem[tmpl_wr_addr] <= PWDATA_IN[7:0];
        end
    end

    for (genvar t = 0; t < `CSF_TMPL_COUNT; t++)
    begin : g_tlen
        always_ff @(posedge MCLK_IN)
        begin
            if (SYS_RST_IN)
            begin
                tlen_q[t] <= 10'h000;
            end
            else if (wr_acc && (PADDR_IN == `CSF_ADDR_TLEN) && (taddr_sel_q == 3'(t)))
            begin
                // lengths above the template size are clamped
                tlen_q[t] <= (PWDATA_IN[15:0] > 16'(`CSF_TMPL_BYTES)) ?
                    10'(`CSF_TMPL_BYTES) : PWDATA_IN[9:0];
            end
        end
    end

    // status bytes from the frozen snapshot
    assign status_a = {1'b0, 1'b0, 1'b1, snap_q.incr_code, snap_q.dp_code};
    assign status_b = {1'b0, snap_q.zero_not_captured, 1'b1, snap_q.kg,
        snap_q.motion, snap_q.out_of_range,
        snap_q.negative, snap_q.net};
    assign status_c = {1'b0, 1'b0, 1'b1, snap_q.expand, snap_q.print_req,
        snap_q.unit_code};

    // leading zero blanking; the last digit always shows
    for (genvar i = 0; i < 6; i++)
    begin : g_digit
        logic lead_w;
        logic lead_t;
        if (i == 5)
        begin : g_msd
            assign lead_w = (snap_q.wt_bcd[i] == 4'h0);
            assign lead_t = (snap_q.tare_bcd[i] == 4'h0);
        end
        else if (i == 0)
        begin : g_lsd
            assign lead_w = 1'b0;
            assign lead_t = 1'b0;
        end
        else
        begin : g_mid
            assign lead_w = g_digit[i + 1].lead_w && (snap_q.wt_bcd[i] == 4'h0);
            assign lead_t = g_digit[i + 1].lead_t && (snap_q.tare_bcd[i] == 4'h0);
        end
        assign wt_chr[5 - i] = lead_w ? `CSF_ASCII_SPACE :
            (`CSF_ASCII_ZERO | {4'h0, snap_q.wt_bcd[i]});
        assign ta_chr[5 - i] = lead_t ? `CSF_ASCII_SPACE :
            (`CSF_ASCII_ZERO | {4'h0, snap_q.tare_bcd[i]});
    end

    always_comb
    begin
        frame_byte = 8'h00;
        case (idx_q)
            10'd0: frame_byte = `CSF_STX;
            10'd1: frame_byte = status_a;
            10'd2: frame_byte = status_b;
            10'd3: frame_byte = status_c;
            10'd4, 10'd5, 10'd6, 10'd7, 10'd8, 10'd9:
                frame_byte = wt_chr[3'(idx_q - 10'd4)];
            10'd10, 10'd11, 10'd12, 10'd13, 10'd14, 10'd15:
                frame_byte = ta_chr[3'(idx_q - 10'd10)];
            10'd16: frame_byte = `CSF_CR;
            10'd17: frame_byte = {1'b0, 7'h00 - sum_q};
            default: frame_byte = 8'h00;
        endcase
    end

    assign next_byte = cap_tmpl_q ? tmpl_mem[tmpl_rd_addr] : frame_byte;

    // pacing: 50 ms minimum from one frame start to the next, so short frames
    // run at 20 per second and slow lines throttle themselves via ready
    assign gap_done = (ms_q >= `CSF_FRAME_GAP_MS);
    assign start_len = ctrl_q[`CSF_CTRL_TMPL] ?
        ((ctrl_q[`CSF_CTRL_SEL_LO +: 3] < 3'(`CSF_TMPL_COUNT)) ?
        tlen_q[ctrl_q[`CSF_CTRL_SEL_LO +: 3]] : 10'h000) :
        (ctrl_q[`CSF_CTRL_CHK] ? `CSF_FRAME_LEN_CHK : `CSF_FRAME_LEN);
    assign start_ok = ctrl_q[`CSF_CTRL_EN] && gap_done && (start_len != 10'h000);

    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            tick_q <= 17'h0_0000;
            ms_q <= `CSF_FRAME_GAP_MS;
        end
        else if ((state_q == csf_pkg::TX_IDLE) && start_ok)
        begin
            tick_q <= 17'h0_0000;
            ms_q <= 6'h00;
        end
        else if (tick_q == 17'(TICK_CYC - 1))
        begin
            tick_q <= 17'h0_0000;
            if (!gap_done)
            begin
                ms_q <= ms_q + 6'h01;
            end
        end
        else
        begin
            tick_q <= tick_q + 17'h0_0001;
        end
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            state_q <= csf_pkg::TX_IDLE;
            snap_q <= '0;
            cap_tmpl_q <= 1'b0;
            cap_sel_q <= 3'h0;
            cap_len_q <= 10'h000;
            idx_q <= 10'h000;
            sum_q <= 7'h00;
            tx_data_q <= 8'h00;
            tx_valid_q <= 1'b0;
            frame_cnt_q <= 16'h0000;
        end
        else
        begin
            case (state_q)
                csf_pkg::TX_IDLE:
                begin
                    if (start_ok)
                    begin
                        snap_q <= SCALE_IN;
                        cap_tmpl_q <= ctrl_q[`CSF_CTRL_TMPL];
                        cap_sel_q <= ctrl_q[`CSF_CTRL_SEL_LO +: 3];
                        cap_len_q <= start_len;
                        idx_q <= 10'h000;
                        sum_q <= 7'h00;
                        state_q <= csf_pkg::TX_LOAD;
                    end
                end
                csf_pkg::TX_LOAD:
                begin
                    // a paused link holds the next byte back
                    if (!paused_q)
                    begin
                        tx_data_q <= next_byte;
                        tx_valid_q <= 1'b1;
                        state_q <= csf_pkg::TX_SEND;
                    end
                end
                csf_pkg::TX_SEND:
                begin
                    // byte in progress always completes
                    if (TX_READY_IN)
                    begin
                        tx_valid_q <= 1'b0;
                        sum_q <= sum_q + tx_data_q[6:0];
                        if (idx_q == cap_len_q - 10'h001)
                        begin
                            frame_cnt_q <= frame_cnt_q + 16'h0001;
                            state_q <= csf_pkg::TX_IDLE;
                        end
                        else
                        begin
                            idx_q <= idx_q + 10'h001;
                            state_q <= csf_pkg::TX_LOAD;
                        end
                    end
                end
                default:
                begin
                    tx_valid_q <= 1'b0;
                    state_q <= csf_pkg::TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            paused_q <= 1'b0;
        end
        else if (!ctrl_q[`CSF_CTRL_FLOW])
        begin
            paused_q <= 1'b0;
        end
        else if (RX_VALID_IN && (RX_DATA_IN == `CSF_XON))
        begin
            paused_q <= 1'b0;
        end
        else if (RX_VALID_IN && (RX_DATA_IN == `CSF_XOFF))
        begin
            paused_q <= 1'b1;
        end
    end

    // codes 0x40 to 0x7f only: folding case on other codes could alias punctuation
    assign rx_upper = RX_DATA_IN & `CSF_CASE_MASK;
    assign rx_cmd_ok = RX_VALID_IN && ctrl_q[`CSF_CTRL_CMD] && (RX_DATA_IN[7:6] == 2'b01);
    assign cmd_hit = rx_cmd_ok ? {(rx_upper == `CSF_CMD_ZERO), (rx_upper == `CSF_CMD_PRINT),
        (rx_upper == `CSF_CMD_TARE), (rx_upper == `CSF_CMD_CLEAR)} : 4'h0;

    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            cmd_pulse_q <= 4'h0;
        end
        else
        begin
            cmd_pulse_q <= cmd_hit;
        end
    end

    // sticky record; a new command wins over a same-cycle clear
    always_ff @(posedge MCLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            cmd_flags_q <= 4'h0;
        end
        else
        begin
            cmd_flags_q <= (cmd_flags_q & ~(cmd_wr ? PWDATA_IN[3:0] : 4'h0)) | cmd_hit;
        end
    end

    assign PRDATA_OUT = prdata_q;
    assign PREADY_OUT = pready_q;
    assign PSLVERR_OUT = pslverr_q;
    assign TX_DATA_OUT = tx_data_q;
    assign TX_VALID_OUT = tx_valid_q;
    assign CLEAR_OUT = cmd_pulse_q[0];
    assign TARE_OUT = cmd_pulse_q[1];
    assign PRINT_OUT = cmd_pulse_q[2];
    assign ZERO_OUT = cmd_pulse_q[3];
endmodule : csf_framer

// ### csf_framer_chk_sva.sv
module csf_framer_chk #(
    parameter int TICK_CYC = 100000
) (
    input wire logic MCLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    input wire logic [7:0] TX_DATA_OUT,
    input wire logic TX_VALID_OUT,
    input wire logic TX_READY_IN,
    input wire logic [7:0] RX_DATA_IN,
    input wire logic RX_VALID_IN,
    input wire logic CLEAR_OUT,
    input wire logic TARE_OUT,
    input wire logic PRINT_OUT,
    input wire logic ZERO_OUT
);
    localparam int GAP = 50 * TICK_CYC;
    logic [7:0] ctrl_q;
    logic [4:0] pos_q;
    logic [6:0] sum_q;
    logic paused_q;
    logic vld_q;
    logic seen_q;
    logic [31:0] gap_q;
    // position tracking assumes control is only rewritten between frames
    wire wr = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && !PSLVERR_OUT &&
        PADDR_IN == 8'h00;
    wire acc = TX_VALID_OUT && TX_READY_IN;
    wire std = !ctrl_q[2];
    wire cmd_en = ctrl_q[6];
    wire rx_flow = RX_VALID_IN && ctrl_q[7];
    wire rise0 = TX_VALID_OUT && !vld_q && pos_q == 5'd0 && std;

    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    always_ff @(posedge MCLK_IN)
        if (SYS_RST_IN)
            ctrl_q <= 8'h00;
        else if (wr)
            ctrl_q <= PWDATA_IN[7:0];
    always_ff @(posedge MCLK_IN)
        if (SYS_RST_IN || wr)
            pos_q <= 5'd0;
        else if (acc)
            pos_q <= (pos_q == 5'd17 || (pos_q == 5'd16 && !ctrl_q[1])) ? 5'd0 : pos_q + 5'd1;
    always_ff @(posedge MCLK_IN)
        if (acc)
            sum_q <= (pos_q == 5'd0 ? 7'h00 : sum_q) + TX_DATA_OUT[6:0];
    always_ff @(posedge MCLK_IN)
        if (SYS_RST_IN || (wr && !PWDATA_IN[7]))
            paused_q <= 1'b0;
        else if (rx_flow && RX_DATA_IN == 8'h13)
            paused_q <= 1'b1;
        else if (rx_flow && RX_DATA_IN == 8'h11)
            paused_q <= 1'b0;
    always_ff @(posedge MCLK_IN)
        vld_q <= !SYS_RST_IN && TX_VALID_OUT;
    always_ff @(posedge MCLK_IN)
        if (SYS_RST_IN)
            seen_q <= 1'b0;
        else if (rise0)
            seen_q <= 1'b1;
    always_ff @(posedge MCLK_IN)
        gap_q <= rise0 ? 32'd1 : gap_q + 32'(gap_q != 32'hffffffff);

    chk_tare_pulse: assert property (
        RX_VALID_IN && cmd_en && (RX_DATA_IN & 8'hdf) == 8'h54 |=> TARE_OUT)
        else $error("tare pulse missing");
    chk_clear_cause: assert property (
        CLEAR_OUT |-> $past(RX_VALID_IN) && $past(cmd_en) && ($past(RX_DATA_IN) & 8'hdf) == 8'h43)
        else $error("clear pulse without its letter");
    chk_other_quiet: assert property (
        RX_VALID_IN && !((RX_DATA_IN & 8'hdf) inside {8'h43, 8'h54, 8'h50, 8'h5a})
        |=> !(CLEAR_OUT || TARE_OUT || PRINT_OUT || ZERO_OUT))
        else $error("action on foreign character");
    chk_tx_hold: assert property (
        TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_DATA_OUT))
        else $error("byte dropped before acceptance");
    chk_pause_hold: assert property (
        paused_q && $past(paused_q) && !TX_VALID_OUT |=> !TX_VALID_OUT)
        else $error("byte presented while paused");
    chk_stx_first: assert property (
        acc && std && pos_q == 5'd0 |-> TX_DATA_OUT == 8'h02)
        else $error("frame does not open with start code");
    chk_cr_byte: assert property (
        acc && std && pos_q == 5'd16 |-> TX_DATA_OUT == 8'h0d)
        else $error("carriage return misplaced");
    chk_status_ac: assert property (
        acc && std && (pos_q == 5'd1 || pos_q == 5'd3) |-> TX_DATA_OUT[7:5] == 3'b001)
        else $error("fixed status bits wrong");
    chk_status_b: assert property (
        acc && std && pos_q == 5'd2 |-> TX_DATA_OUT[7] == 1'b0 && TX_DATA_OUT[5])
        else $error("status B fixed bit wrong");
    chk_digit_ascii: assert property (
        acc && std && pos_q inside {[5'd4:5'd15]} |->
        TX_DATA_OUT == 8'h20 || TX_DATA_OUT[7:4] == 4'h3)
        else $error("digit field not a digit or space");
    chk_sum_byte: assert property (
        acc && std && pos_q == 5'd17 |-> TX_DATA_OUT == {1'b0, 7'h00 - sum_q})
        else $error("checksum wrong");
    chk_frame_gap: assert property (
        rise0 && seen_q |-> gap_q >= 32'(GAP))
        else $error("frames too close");

    cov_sum: cover property (acc && std && pos_q == 5'd17);
    cov_pause: cover property (paused_q && TX_VALID_OUT && TX_READY_IN);
    cov_tmpl: cover property (acc && !std);
endmodule : csf_framer_chk

bind csf_framer csf_framer_chk #(.TICK_CYC(TICK_CYC)) i_csf_framer_chk (
    .MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .TX_DATA_OUT(TX_DATA_OUT), .TX_VALID_OUT(TX_VALID_OUT),
    .TX_READY_IN(TX_READY_IN), .RX_DATA_IN(RX_DATA_IN), .RX_VALID_IN(RX_VALID_IN),
    .CLEAR_OUT(CLEAR_OUT), .TARE_OUT(TARE_OUT), .PRINT_OUT(PRINT_OUT), .ZERO_OUT(ZERO_OUT));

// ### csf_uart_model.sv
module csf_uart_model (
    input wire logic clk_in,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    output logic [7:0] rx_data_out,
    output logic rx_valid_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic slow = 1'b0;
    logic [1:0] ph = 2'd0;
    logic [7:0] got[$];
    // a stalling receiver takes one byte in four cycles
    assign tx_ready_out = !slow || ph == 2'd0;
    always @(posedge clk_in)
    begin
        ph <= ph + 2'd1;
        if (tx_valid_in && tx_ready_out)
            got.push_back(tx_data_in);
    end
    initial
    begin
        rx_valid_out = 1'b0;
        rx_data_out = 8'h00;
    end
    task automatic send(input logic [7:0] b);
        @(posedge clk_in);
        rx_data_out <= b;
        rx_valid_out <= 1'b1;
        @(posedge clk_in);
        rx_valid_out <= 1'b0;
        rx_data_out <= ~b; // idle line must not echo the last byte
    endtask : send
endmodule : csf_uart_model

// ### tb_continuous_scale_output_framer.sv
module tb_continuous_scale_output_framer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] ROWS [11] = '{12'h438, 12'h744, 12'h702, 12'h7a1, 12'h638,
        12'h544, 12'h502, 12'h5a1, 12'h410, 12'h780, 12'h110};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, tx_valid, tx_ready, rx_valid, clr, tare, prt, zro;
    logic [7:0] tx_data, rx_data;
    csf_pkg::csf_scale_t scale = '0;
    int err_count = 0;
    int num_checks = 0;
    logic [7:0] ef [18];
    logic [31:0] rd;
    logic se;
    int n;

    csf_framer #(.TICK_CYC(10)) i_csf_framer (.MCLK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .SCALE_IN(scale),
        .TX_DATA_OUT(tx_data), .TX_VALID_OUT(tx_valid), .TX_READY_IN(tx_ready),
        .RX_DATA_IN(rx_data), .RX_VALID_IN(rx_valid), .CLEAR_OUT(clr), .TARE_OUT(tare),
        .PRINT_OUT(prt), .ZERO_OUT(zro));
    csf_uart_model i_csf_uart_model (.clk_in(clk), .tx_data_in(tx_data), .tx_valid_in(tx_valid),
        .tx_ready_out(tx_ready), .rx_data_out(rx_data), .rx_valid_out(rx_valid));

    initial forever #5 clk = ~clk;

    task automatic summarize();
        if (err_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("unexpected %s: expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        check("pready", 32'h1, 32'(pready));
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    task automatic wait_n(input int cnt);
        int k;
        k = 0;
        while (i_csf_uart_model.got.size() < cnt && k < 5000)
        begin
            @(posedge clk);
            k++;
        end
        check("byte count", cnt, i_csf_uart_model.got.size());
    endtask : wait_n

    // expected fixed frame, worked out field by field
    function automatic void mk(input csf_pkg::csf_scale_t s);
        logic [6:0] sum;
        logic lw;
        logic lt;
        ef[0] = 8'h02;
        ef[1] = {3'b001, s.incr_code, s.dp_code};
        ef[2] = {1'b0, s.zero_not_captured, 1'b1, s.kg, s.motion, s.out_of_range,
            s.negative, s.net};
        ef[3] = {3'b001, s.expand, s.print_req, s.unit_code};
        lw = 1'b1;
        lt = 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            lw = lw && s.wt_bcd[5 - i] == 4'h0 && i < 5;
            lt = lt && s.tare_bcd[5 - i] == 4'h0 && i < 5;
            ef[4 + i] = lw ? 8'h20 : {4'h3, s.wt_bcd[5 - i]};
            ef[10 + i] = lt ? 8'h20 : {4'h3, s.tare_bcd[5 - i]};
        end
        ef[16] = 8'h0d;
        sum = 7'h00;
        for (int i = 0; i < 17; i++)
            sum = sum + ef[i][6:0];
        ef[17] = {1'b0, 7'h00 - sum};
    endfunction : mk

    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        summarize();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("outputs after reset", 32'h0, {tx_valid, clr, tare, prt, zro, pready});
        apb(1'b0, 8'h1c, 32'h0);
        check("unmapped error", 32'h1, se);
        apb(1'b1, 8'h00, 32'h40);
        foreach (ROWS[i])
        begin
            i_csf_uart_model.send(ROWS[i][11:4]);
            @(posedge clk);
            check("commands", ROWS[i][3:0], {clr, tare, prt, zro});
        end
        apb(1'b0, 8'h14, 32'h0);
        check("sticky commands", 32'hf, rd);
        apb(1'b1, 8'h14, 32'hf);
        apb(1'b0, 8'h14, 32'h0);
        check("commands cleared", 32'h0, rd);
        // checksum frame under stalls, paused mid-frame, scale changed after start
        scale <= {24'h001205, 24'h000000, 3'b100, 2'b01, 6'b100110, 3'b001, 2'b10};
        i_csf_uart_model.slow <= 1'b1;
        apb(1'b1, 8'h00, 32'hc3);
        mk(scale);
        wait_n(1);
        scale.wt_bcd <= 24'h999999;
        wait_n(5);
        i_csf_uart_model.send(8'h13);
        repeat (6) @(posedge clk);
        n = i_csf_uart_model.got.size();
        apb(1'b0, 8'h10, 32'h0);
        check("paused status", 32'h5, 32'(rd[3:0]));
        repeat (30) @(posedge clk);
        check("held while paused", n, i_csf_uart_model.got.size());
        i_csf_uart_model.send(8'h11);
        wait_n(18);
        apb(1'b1, 8'h00, 32'h40);
        check("frame length", 32'd18, i_csf_uart_model.got.size());
        for (int i = 0; i < 4; i++)
            check("frame head", ef[i], i_csf_uart_model.got[i]);
        check("status b", ef[2], i_csf_uart_model.got[2]);
        check("status c", ef[3], i_csf_uart_model.got[3]);
        for (int i = 4; i < 16; i++)
            check("frame digits", ef[i], i_csf_uart_model.got[i]);
        for (int i = 16; i < 18; i++)
            check("frame tail", ef[i], i_csf_uart_model.got[i]);
        // two plain frames back to back expose the 17 byte length
        i_csf_uart_model.got.delete();
        i_csf_uart_model.slow <= 1'b0;
        mk(scale);
        apb(1'b1, 8'h00, 32'h41);
        wait_n(34);
        apb(1'b1, 8'h00, 32'h40);
        apb(1'b0, 8'h18, 32'h0);
        check("frame count", 32'd3, rd);
        for (int i = 0; i < 17; i++)
            check("plain frame", ef[i], i_csf_uart_model.got[i]);
        check("next frame start", 32'h02, i_csf_uart_model.got[17]);
        i_csf_uart_model.got.delete();
        apb(1'b1, 8'h04, 32'h00020000);
        for (int i = 0; i < 3; i++)
            apb(1'b1, 8'h08, 32'h41 + 32'(i));
        apb(1'b1, 8'h0c, 32'd1005);
        apb(1'b0, 8'h0c, 32'h0);
        check("template length clamp", 32'd1000, rd);
        apb(1'b1, 8'h0c, 32'd3);
        apb(1'b1, 8'h00, 32'h57);
        wait_n(6);
        apb(1'b1, 8'h00, 32'h40);
        for (int i = 0; i < 6; i++)
            check("template byte", 32'h41 + 32'(i % 3), i_csf_uart_model.got[i]);
        summarize();
    end
endmodule : tb_continuous_scale_output_framer
